// File: testbench/sacd_checker_properties.sv
`include "sacd_defines.vh"
module sacd_checker (
    // System
    input wire logic                    sys_clk_i,
    input wire logic                    rst_i,
    input wire logic                    bit_clk_i,
    input wire logic                    run_request_i,
    // Stream and status
    input wire logic                    sample_valid_o,
    input wire logic                    sample_ready_i,
    input wire logic [`SACD_WORD_W-1:0] sample_data_o,
    input wire logic                    clock_error_o,
    input wire logic                    clock_halt_o,
    input wire logic                    outputs_hiz_o,
    input wire logic                    running_o,
    input wire logic                    overflow_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] idle_reg;
    logic        seen_reg;
    logic        prev_reg;
    // Cycles since the last raw bit clock rise
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || (bit_clk_i && !prev_reg)) begin
            idle_reg <= 11'h000;
        end else if (idle_reg != 11'h7FF) begin
            idle_reg <= idle_reg + 11'h001;
        end
        seen_reg <= !rst_i && (seen_reg || bit_clk_i);
        prev_reg <= bit_clk_i;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_bit_rise; $rose(bit_clk_i); endsequence
    sequence s_halted; clock_halt_o && outputs_hiz_o && clock_error_o && !running_o; endsequence
    property p_reset_state;
        disable iff (1'b0) rst_i |=> outputs_hiz_o && !running_o && !sample_valid_o;
    endproperty
    property p_halt_outputs; clock_halt_o |-> s_halted; endproperty
    property p_halt_late; $rose(clock_halt_o) |-> idle_reg >= 11'h3E3; endproperty
    property p_halt_bound; seen_reg && idle_reg == 11'h3F7 |-> clock_halt_o; endproperty
    property p_halt_clear; clock_halt_o ##0 s_bit_rise |-> ##[1:8] !clock_halt_o; endproperty
    property p_valid_hold;
        sample_valid_o && !sample_ready_i |=> sample_valid_o && $stable(sample_data_o);
    endproperty
    property p_ovf_sticky; overflow_o |=> overflow_o; endproperty
    property p_run_not_hiz; running_o |-> !outputs_hiz_o; endproperty
    property p_run_request; $rose(running_o) |-> run_request_i; endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    a_halt_outputs: assert property (p_halt_outputs) else $error("halt flags wrong");
    a_halt_late: assert property (p_halt_late) else $error("halt too early");
    a_halt_bound: assert property (p_halt_bound) else $error("halt too late");
    a_halt_clear: assert property (p_halt_clear) else $error("halt not cleared");
    a_valid_hold: assert property (p_valid_hold) else $error("held word lost");
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped");
    a_run_not_hiz: assert property (p_run_not_hiz) else $error("hiz while running");
    a_run_request: assert property (p_run_request) else $error("run without request");
endmodule // sacd_checker

bind sacd_serial_audio_clock_input sacd_checker i_sacd_checker (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bit_clk_i(bit_clk_i), .run_request_i(run_request_i),
    .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i),
    .sample_data_o(sample_data_o), .clock_error_o(clock_error_o), .clock_halt_o(clock_halt_o),
    .outputs_hiz_o(outputs_hiz_o), .running_o(running_o), .overflow_o(overflow_o));

// File: testbench/sacd_host_link.sv
module sacd_host_link (
    // Serial audio link
    output logic bit_clk_o,
    output logic ws_o,
    output logic data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bit_clk_o = 1'b0;
        ws_o = 1'b0;
        data_o = 1'b0;
    end
    // data and word clock move on the falling edge
    task automatic send_word(input logic [31:0] w, input int nbits, input logic lvl,
                             input logic pulse, input int half);
        for (int i = nbits - 1; i >= 0; i--) begin
            bit_clk_o = 1'b0;
            ws_o = (i == nbits - 1 || !pulse) ? lvl : 1'b0;
            data_o = w[i];
            #half;
            bit_clk_o = 1'b1;
            #half;
        end
    endtask
    // clock stands still, data line carries no stale value
    task automatic idle(input int ns);
        bit_clk_o = 1'b0;
        repeat (ns / 100) begin
            data_o = ~data_o;
            #100;
        end
    endtask
endmodule // sacd_host_link

// File: testbench/tb.sv
`include "sacd_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, rst_i, clk_en_i, tdm_mode_i, run_request_i, sample_ready_i;
    logic bit_clk_i, word_select_frame_sync_i, serial_audio_in_i;
    logic sample_valid_o, clock_error_o, clock_halt_o, outputs_hiz_o;
    logic running_o, proc_clk_tick_o, overflow_o, rdy, chk_on, synced, stall, counting;
    logic [`SACD_WORD_W-1:0] sample_data_o;
    logic [`SACD_SLOT_W-1:0] sample_slot_o;
    logic [`SACD_RATE_W-1:0] rate_class_o;
    logic [31:0] seed = 32'h8E2CC23D;
    logic [34:0] exp_q[$];
    int errors = 0, tests_run = 0, ticks = 0;
    int halfs[3] = '{500, 325, 162};
    logic [1:0] rates[3] = '{`SACD_RATE_32K, `SACD_RATE_48K, `SACD_RATE_96K};

    sacd_serial_audio_clock_input i_sacd_serial_audio_clock_input (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .bit_clk_i(bit_clk_i),
        .word_select_frame_sync_i(word_select_frame_sync_i),
        .serial_audio_in_i(serial_audio_in_i), .tdm_mode_i(tdm_mode_i),
        .run_request_i(run_request_i), .sample_valid_o(sample_valid_o),
        .sample_ready_i(sample_ready_i), .sample_data_o(sample_data_o),
        .sample_slot_o(sample_slot_o), .rate_class_o(rate_class_o),
        .clock_error_o(clock_error_o), .clock_halt_o(clock_halt_o),
        .outputs_hiz_o(outputs_hiz_o), .running_o(running_o),
        .proc_clk_tick_o(proc_clk_tick_o), .overflow_o(overflow_o));
    sacd_host_link i_sacd_host_link (.bit_clk_o(bit_clk_i),
        .ws_o(word_select_frame_sync_i), .data_o(serial_audio_in_i));

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] exp_slot(input logic odd);
        return {2'h0, odd};
    endfunction
    task automatic check_val(input string name, input logic [34:0] exp, input logic [34:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_flag(input string name, input logic exp, input logic got);
        check_val(name, {34'h0, exp}, {34'h0, got});
    endtask
    task automatic tally_and_finish();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Sends whole frames of random words, left word with the word clock high
    task automatic burst(input int frames, input int nbits, input int half, input logic tdm);
        logic [31:0] w;
        synced = 1'b0;
        #37;
        for (int f = 0; f < frames * (tdm ? 4 : 2); f++) begin
            w = xorshift();
            if (chk_on) exp_q.push_back({exp_slot(f[0]), w});
            i_sacd_host_link.send_word(w, nbits, tdm ? (f % 4 == 0) : !f[0], tdm, half);
        end
        @(negedge sys_clk_i);
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // ============
    // Consumer: random ready, checks each word popped while chk_on is set
    always @(negedge sys_clk_i) begin
        rdy = !stall && (xorshift() % 4 != 0);
        sample_ready_i <= rdy;
        if (chk_on && rdy && sample_valid_o === 1'b1) begin
            while (!synced && exp_q.size() > 1 && exp_q[0] !== {sample_slot_o, sample_data_o})
                void'(exp_q.pop_front());
            synced = 1'b1;
            check_val("sample", exp_q.size() > 0 ? exp_q.pop_front() : 35'h0,
                      {sample_slot_o, sample_data_o});
        end
    end
    always @(posedge sys_clk_i) if (counting && proc_clk_tick_o === 1'b1) ticks++;
    initial begin
        #3ms;
        errors++;
        tally_and_finish();
    end
    // ============
    initial begin
        {rst_i, clk_en_i, tdm_mode_i, run_request_i} = 4'hC;
        {chk_on, synced, stall, counting} = 4'h0;
        repeat (3) @(negedge sys_clk_i);
        rst_i = 1'b0;
        check_flag("hiz after reset", 1'b1, outputs_hiz_o);
        foreach (halfs[k]) begin
            burst(6, 16, halfs[k], 1'b0);
            check_val("rate class", {33'h0, rates[k]}, {33'h0, rate_class_o});
            i_sacd_host_link.idle(150000);
            @(negedge sys_clk_i);
            check_flag("halted", 1'b1, clock_halt_o);
            check_flag("halt error", 1'b1, clock_error_o);
        end
        run_request_i = 1'b1;
        chk_on = 1'b1;
        burst(20, 32, 162, 1'b0);
        check_flag("running", 1'b1, running_o);
        i_sacd_host_link.idle(150000);
        @(negedge sys_clk_i);
        check_flag("hiz on halt", 1'b1, outputs_hiz_o);
        burst(4, 32, 162, 1'b0);
        check_flag("run restored", 1'b1, running_o);
        check_flag("halt cleared", 1'b0, clock_halt_o);
        stall = 1'b1;
        burst(6, 32, 162, 1'b0);
        check_flag("full valid", 1'b1, sample_valid_o);
        check_flag("overflow", 1'b1, overflow_o);
        {stall, chk_on} = 2'h0;
        clk_en_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        check_flag("frozen valid", 1'b1, sample_valid_o);
        clk_en_i = 1'b1;
        i_sacd_host_link.idle(20000);
        @(negedge sys_clk_i);
        check_flag("drained", 1'b0, sample_valid_o);
        tdm_mode_i = 1'b1;
        counting = 1'b1;
        burst(4, 32, 400, 1'b1);
        counting = 1'b0;
        check_flag("tick count", 1'b1, ticks > 3686 && ticks < 4506);
        check_flag("tdm rate error", 1'b1, clock_error_o);
        check_val("tdm rate", 35'h0, {33'h0, rate_class_o});
        tally_and_finish();
    end
endmodule // tb

// File: verilog/sacd_defines.vh
`ifndef SACD_DEFINES_VH
`define SACD_DEFINES_VH

// Clock and timing
`define SACD_SYS_CLK_HZ       10000000
`define SACD_HALT_TIMEOUT_NS  100000
`define SACD_HALT_CYCLES      ((`SACD_HALT_TIMEOUT_NS * (`SACD_SYS_CLK_HZ / 1000000)) / 1000)
`define SACD_CNT_W            16

// Sample rate classes
`define SACD_RATE_W           2
`define SACD_RATE_NONE        2'h0
`define SACD_RATE_32K         2'h1
`define SACD_RATE_48K         2'h2
`define SACD_RATE_96K         2'h3

// Supported bit clocks per frame
`define SACD_RATIO_32         16'h0020
`define SACD_RATIO_64         16'h0040
`define SACD_RATIO_128        16'h0080
`define SACD_RATIO_256        16'h0100
`define SACD_RATIO_512        16'h0200

// Frame period bounds in system clocks (32k about 312, 48k 208, 96k 104)
`define SACD_P32_MIN          16'h0118
`define SACD_P32_MAX          16'h0158
`define SACD_P48_MIN          16'h00BE
`define SACD_P48_MAX          16'h00EE
`define SACD_P96_MIN          16'h005A
`define SACD_P96_MAX          16'h0078

// Processing clock multiplier over bit clock
`define SACD_PLL_MULT         4'h8

// Data path
`define SACD_WORD_W           32
`define SACD_SLOT_W           3

`endif

// File: verilog/sacd_serial_audio_clock_input.v
`include "sacd_defines.vh"

module sacd_serial_audio_clock_input (
    // System
    input  wire                      sys_clk_i,
    input  wire                      rst_i,
    input  wire                      clk_en_i,
    // Serial audio link
    input  wire                      bit_clk_i,
    input  wire                      word_select_frame_sync_i,
    input  wire                      serial_audio_in_i,
    // Mode
    input  wire                      tdm_mode_i,
    input  wire                      run_request_i,
    // Sample stream
    output wire                      sample_valid_o,
    input  wire                      sample_ready_i,
    output wire [`SACD_WORD_W-1:0]   sample_data_o,
    output wire [`SACD_SLOT_W-1:0]   sample_slot_o,
    // Status
    output reg  [`SACD_RATE_W-1:0]   rate_class_o,
    output reg                       clock_error_o,
    output reg                       clock_halt_o,
    output reg                       outputs_hiz_o,
    output reg                       running_o,
    output reg                       proc_clk_tick_o,
    output reg                       overflow_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_HALT = 2'h2;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    reg  [2:0] sync1_reg;
    reg  [2:0] sync2_reg;
    reg  [1:0] prev_reg;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg  <= 2'h0;
        end else if (clk_en_i) begin
            sync1_reg <= {serial_audio_in_i, word_select_frame_sync_i, bit_clk_i};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg[1:0];
        end
    end

    wire bclk_rise = sync2_reg[0] & ~prev_reg[0];
    wire ws_edge   = sync2_reg[1] ^ prev_reg[1];
    wire ws_rise   = sync2_reg[1] & ~prev_reg[1];
    wire frame_mark = tdm_mode_i ? ws_rise : ws_edge;
    wire frame_start = tdm_mode_i ? ws_rise : ws_rise;

    // ==========================================================
    // Halt detection
    // ==========================================================
    reg  [`SACD_CNT_W-1:0] idle_cnt_reg;
    wire halted_now = (idle_cnt_reg >= `SACD_HALT_CYCLES);
    always @(posedge sys_clk_i) begin
        if (rst_i)
            idle_cnt_reg <= {`SACD_CNT_W{1'b0}};
        else if (clk_en_i) begin
            if (bclk_rise)
                idle_cnt_reg <= {`SACD_CNT_W{1'b0}};
            else if (!halted_now)
                idle_cnt_reg <= idle_cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // Rate and ratio detection
    // ==========================================================
    reg  [`SACD_CNT_W-1:0] bits_cnt_reg;
    reg  [`SACD_CNT_W-1:0] per_cnt_reg;
    reg                    seen_frame_reg;
    reg                    ratio_ok_reg;
    function [`SACD_RATE_W-1:0] rate_of;
        input [`SACD_CNT_W-1:0] p;
        begin
            if (p >= `SACD_P32_MIN && p <= `SACD_P32_MAX)
                rate_of = `SACD_RATE_32K;
            else if (p >= `SACD_P48_MIN && p <= `SACD_P48_MAX)
                rate_of = `SACD_RATE_48K;
            else if (p >= `SACD_P96_MIN && p <= `SACD_P96_MAX)
                rate_of = `SACD_RATE_96K;
            else
                rate_of = `SACD_RATE_NONE;
        end
    endfunction
    function ratio_valid;
        input [`SACD_CNT_W-1:0] n;
        input                   tdm;
        begin
            if (tdm)
                ratio_valid = (n == `SACD_RATIO_128) || (n == `SACD_RATIO_256) ||
                              (n == `SACD_RATIO_512);
            else
                ratio_valid = (n == `SACD_RATIO_32) || (n == `SACD_RATIO_64) ||
                              (n == `SACD_RATIO_128);
        end
    endfunction
    wire [`SACD_RATE_W-1:0] rate_now = rate_of(per_cnt_reg);
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            bits_cnt_reg   <= {`SACD_CNT_W{1'b0}};
            per_cnt_reg    <= {`SACD_CNT_W{1'b0}};
            seen_frame_reg <= 1'b0;
            ratio_ok_reg   <= 1'b0;
            rate_class_o   <= `SACD_RATE_NONE;
        end else if (clk_en_i) begin
            if (halted_now) begin
                seen_frame_reg <= 1'b0;
                bits_cnt_reg   <= {`SACD_CNT_W{1'b0}};
                per_cnt_reg    <= {`SACD_CNT_W{1'b0}};
            end else if (frame_start) begin
                seen_frame_reg <= 1'b1;
                if (seen_frame_reg) begin
                    ratio_ok_reg <= ratio_valid(bits_cnt_reg, tdm_mode_i) &&
                                    (rate_now != `SACD_RATE_NONE);
                    rate_class_o <= rate_now;
                end
                bits_cnt_reg <= {`SACD_CNT_W{1'b0}};
                per_cnt_reg  <= {`SACD_CNT_W{1'b0}};
            end else begin
                if (bclk_rise && bits_cnt_reg != {`SACD_CNT_W{1'b1}})
                    bits_cnt_reg <= bits_cnt_reg + 1'b1;
                if (per_cnt_reg != {`SACD_CNT_W{1'b1}})
                    per_cnt_reg <= per_cnt_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // Operating state
    // ==========================================================
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg       saved_run_reg;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (halted_now)
                    state_next = ST_HALT;
                else if (run_request_i && ratio_ok_reg)
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if (halted_now)
                    state_next = ST_HALT;
                else if (!run_request_i)
                    state_next = ST_IDLE;
            end
            ST_HALT: begin
                if (!halted_now && ratio_ok_reg)
                    state_next = saved_run_reg ? ST_RUN : ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg       <= ST_IDLE;
            saved_run_reg   <= 1'b0;
            clock_error_o   <= 1'b0;
            clock_halt_o    <= 1'b0;
            outputs_hiz_o   <= 1'b1;
            running_o       <= 1'b0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            if (state_reg == ST_RUN && state_next == ST_HALT)
                saved_run_reg <= 1'b1;
            else if (state_reg == ST_IDLE && state_next == ST_HALT)
                saved_run_reg <= 1'b0;
            clock_error_o <= (state_next == ST_HALT) || (seen_frame_reg && !ratio_ok_reg);
            clock_halt_o  <= (state_next == ST_HALT);
            outputs_hiz_o <= (state_next != ST_RUN);
            running_o     <= (state_next == ST_RUN);
        end
    end

    // ==========================================================
    // Processing clock tick, bit clock times multiplier
    // ==========================================================
    reg [`SACD_CNT_W-1:0] bper_cnt_reg;
    reg [`SACD_CNT_W-1:0] bper_reg;
    reg [`SACD_CNT_W-1:0] tick_cnt_reg;
    wire [`SACD_CNT_W-1:0] tick_step = bper_reg / {12'h000, `SACD_PLL_MULT};
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            bper_cnt_reg    <= {`SACD_CNT_W{1'b0}};
            bper_reg        <= {`SACD_CNT_W{1'b0}};
            tick_cnt_reg    <= {`SACD_CNT_W{1'b0}};
            proc_clk_tick_o <= 1'b0;
        end else if (clk_en_i) begin
            proc_clk_tick_o <= bclk_rise;
            if (bclk_rise) begin
                bper_reg     <= bper_cnt_reg + 1'b1;
                bper_cnt_reg <= {`SACD_CNT_W{1'b0}};
            end else if (!halted_now)
                bper_cnt_reg <= bper_cnt_reg + 1'b1;
            if (bclk_rise || halted_now)
                tick_cnt_reg <= {`SACD_CNT_W{1'b0}};
            else if (tick_step != {`SACD_CNT_W{1'b0}} && tick_cnt_reg + 1'b1 >= tick_step) begin
                tick_cnt_reg    <= {`SACD_CNT_W{1'b0}};
                proc_clk_tick_o <= 1'b1;
            end else
                tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // Serial shift register and two-entry buffer
    // ==========================================================
    reg [`SACD_WORD_W-1:0] shift_reg;
    reg [`SACD_SLOT_W-1:0] slot_reg;
    reg                    in_valid;
    reg [`SACD_WORD_W-1:0] in_word;
    reg [`SACD_SLOT_W-1:0] in_slot;
    reg [`SACD_WORD_W+`SACD_SLOT_W-1:0] buf_mem [0:1];
    reg                    wr_ptr_reg;
    reg                    rd_ptr_reg;
    reg [1:0]              count_reg;
    wire                   buf_full  = (count_reg == 2'h2);
    wire                   buf_empty = (count_reg == 2'h0);
    wire                   push = in_valid && !buf_full;
    wire                   pop  = !buf_empty && sample_ready_i;
    assign sample_valid_o = !buf_empty;
    assign {sample_data_o, sample_slot_o} = buf_mem[rd_ptr_reg];
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            shift_reg  <= {`SACD_WORD_W{1'b0}};
            slot_reg   <= {`SACD_SLOT_W{1'b0}};
            in_valid   <= 1'b0;
            in_word    <= {`SACD_WORD_W{1'b0}};
            in_slot    <= {`SACD_SLOT_W{1'b0}};
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            overflow_o <= 1'b0;
            buf_mem[0] <= {(`SACD_WORD_W+`SACD_SLOT_W){1'b0}};
            buf_mem[1] <= {(`SACD_WORD_W+`SACD_SLOT_W){1'b0}};
        end else if (clk_en_i) begin
            if (push) begin
                buf_mem[wr_ptr_reg] <= {in_word, in_slot};
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
            if (push)
                in_valid <= 1'b0;
            // Word closes at each boundary while running; a held word blocked by a full buffer is lost
            if (frame_mark)
                slot_reg <= frame_start ? {`SACD_SLOT_W{1'b0}} : slot_reg + 1'b1;
            if (frame_mark && running_o) begin
                if (in_valid && !push)
                    overflow_o <= 1'b1;
                in_valid <= 1'b1;
                in_word  <= shift_reg;
                in_slot  <= slot_reg;
            end
            if (bclk_rise)
                shift_reg <= {shift_reg[`SACD_WORD_W-2:0], sync2_reg[2]};
        end
    end

endmodule // sacd_serial_audio_clock_input
